// ### frame_sink_model.sv
// downstream consumer of the generated clocks and frame pulses
// assumes every timing output of the core is registered on pclk
`timescale 1ns/1ps

module frame_sink_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // timing from the core
   input wire logic [5:0] clocks,
   input wire logic [3:0] frames,
   input wire logic [2:0] offsets,
   // measurements over the last full frame, and a frame pulse mismatch flag sticky from reset
   output logic [15:0] period,
   output logic [2:0][15:0] pos,
   output logic [2:0] hit,
   output logic [5:0][15:0] edges,
   output logic apart
);
   logic [15:0] cnt;
   logic [2:0] seen;
   logic [5:0] prev;
   logic [5:0][15:0] run;
   wire [5:0] rise = clocks & ~prev;

   ////////////////////////////////////////////////////////////////////////////
   // window restarts on every boundary pulse, so counts cover exactly one frame
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 16'h0000;
         seen <= 3'h0;
         prev <= 6'h00;
         run <= '0;
         apart <= 1'b0;
      end else begin
         prev <= clocks;
         apart <= apart | (frames != 4'h0 && frames != 4'hf);
         cnt <= frames[0] ? 16'h0000 : cnt + 16'h0001;
         seen <= frames[0] ? offsets : seen | offsets;
         if (frames[0]) begin
            period <= cnt + 16'h0001;
            hit <= seen;
            edges <= run;
         end
         for (int i = 0; i < 6; i++) begin
            run[i] <= (frames[0] ? 16'h0000 : run[i]) + {15'h0000, rise[i]};
         end
         for (int i = 0; i < 3; i++) begin
            if (offsets[i])
               pos[i] <= frames[0] ? 16'h0000 : cnt + 16'h0001;
         end
      end
   end
endmodule : frame_sink_model

// ### ref_activity_monitor.sv
// activity monitor for one DPLL reference input
// assumes ref_in already synchronous to pclk
`timescale 1ns/1ps
`include "tdm_timing_regs.svh"

module ref_activity_monitor #(
   parameter int TIMEOUT_CYCLES = `REF_TIMEOUT_CYCLES
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // reference
   input wire logic enable,
   input wire logic ref_in,
   output logic fail
);

   tdm_timing_pkg::monitor_state_t r, n;
   logic edge_seen;

   ////////////////////////////////////////////////////////////////
   always_comb begin
      n = r;
      edge_seen = ref_in & ~r.prev;
      n.prev = ref_in;
      if (!enable) begin
         // slave mode ignores the pin and keeps the flag low
         n.count = 16'h0000;
         n.fail = 1'b0;
      end else if (edge_seen) begin
         n.count = 16'h0000;
         n.fail = 1'b0;
      end else if (r.count == 16'(TIMEOUT_CYCLES - 1)) begin
         // window outlasts the slowest 8 kHz reference
         n.fail = 1'b1;
      end else begin
         n.count = r.count + 16'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign fail = r.fail;

   ////////////////////////////////////////////////////////////////
   property p_silent_fails;
      @(posedge pclk) disable iff (!presetn)
      (enable && !edge_seen && r.count == 16'(TIMEOUT_CYCLES - 1)) ##1 enable |-> fail;
   endproperty
   a_silent_fails: assert property (p_silent_fails) else $error("silent reference not flagged");

   property p_edge_clears;
      @(posedge pclk) disable iff (!presetn)
      (enable && edge_seen) |=> !fail;
   endproperty
   a_edge_clears: assert property (p_edge_clears) else $error("active reference flagged");

endmodule : ref_activity_monitor

// ### tdm_timing_core.sv
// clock selection, reference status, output clocks and frame pulses
// assumes synchronous pins, APB master on pclk, DPLL filter outside
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "tdm_timing_regs.svh"

module tdm_timing_core #(
   parameter int FRAME_CYCLES = `FRAME_CYCLES,
   parameter int REF_TIMEOUT_CYCLES = `REF_TIMEOUT_CYCLES
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata,
   // timing source
   input wire logic external_oscillator_present,
   input wire logic input_bit_clock,
   input wire logic input_frame_pulse,
   output logic master_clock_from_oscillator,
   // references
   input wire logic [3:0] dpll_reference_inputs,
   output logic [3:0] reference_loss_flags,
   output logic [1:0] selected_reference,
   output logic reference_valid,
   output logic dpll_reference_out,
   // generated timing
   output logic [5:0] generated_clock_outputs,
   output logic [3:0] aligned_frame_pulses,
   output logic [1:0] offset_frame_pulses,
   output logic third_offset_frame_pulse
);

   localparam int CHAN_CYCLES = (FRAME_CYCLES >= 2 * `CHANNELS_PER_FRAME) ?
                                FRAME_CYCLES / `CHANNELS_PER_FRAME : 1;

   tdm_timing_pkg::timing_state_t r, n;
   logic dpll_active;
   logic [3:0] fail;
   logic [3:0] eff_rate [4];
   logic access;
   logic wr;
   logic boundary;
   logic realign;
   logic [1:0] pick;
   logic [31:0] inc;

   assign dpll_active = (r.mode == tdm_timing_pkg::MODE_MASTER) | r.slv_pll;

   ////////////////////////////////////////////////////////////////
   // reference monitors, one per input
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_mon
         ref_activity_monitor #(
            .TIMEOUT_CYCLES(REF_TIMEOUT_CYCLES)
         ) i_ref_activity_monitor (
            .pclk(pclk),
            .presetn(presetn),
            .enable(dpll_active),
            .ref_in(dpll_reference_inputs[gi]),
            .fail(fail[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////
   always_comb begin
      n = r;
      access = psel & penable & r.pready;
      wr = access & pwrite;
      realign = 1'b0;
      boundary = 1'b0;
      pick = r.preferred;
      inc = 32'h00000000;
      for (int i = 0; i < 4; i++) begin
         eff_rate[i] = 4'h0;
      end

      // zero wait state: answer one cycle after setup
      n.pready = psel & ~penable;
      n.pslverr = 1'b0;
      n.prdata = 32'h00000000;
      if (psel & ~penable) begin
         case (paddr)
            `MAIN_CONTROL_OFFSET: begin
               n.prdata[`CTRL_MODE_LSB +: 2] = r.mode;
               n.prdata[`CTRL_CKI_RATE_LSB +: 2] = r.cki_rate;
               n.prdata[`CTRL_CLK3_RATE_LSB +: 2] = r.clk3_rate;
               n.prdata[`CTRL_CLK4_SEL_BIT] = r.clk4_sel;
               n.prdata[`CTRL_SLAVE_PLL_BIT] = r.slv_pll;
            end
            `REF_CHANGE_OFFSET: begin
               n.prdata[1:0] = r.preferred;
               n.prdata[`RCC_FORCE_BIT] = r.forced;
            end
            `OFFSET0_OFFSET: n.prdata[7:0] = r.off0;
            `OFFSET1_OFFSET: n.prdata[7:0] = r.off1;
            `THIRD_OFFSET_OFFSET: begin
               n.prdata[7:0] = r.off2;
               n.prdata[`SONET_SELECT_BIT] = r.sonet_sel;
            end
            `STATUS_OFFSET: begin
               n.prdata[3:0] = fail & {4{dpll_active}};
               n.prdata[5:4] = r.selected;
               n.prdata[6] = r.ref_valid;
               n.prdata[7] = r.osc_present;
               n.prdata[8] = r.config_error;
            end
            default: n.pslverr = 1'b1;
         endcase
      end
      if (wr) begin
         case (paddr)
            `MAIN_CONTROL_OFFSET: begin
               n.mode = tdm_timing_pkg::timing_mode_t'(pwdata[`CTRL_MODE_LSB +: 2]);
               n.cki_rate = tdm_timing_pkg::clock_rate_t'(pwdata[`CTRL_CKI_RATE_LSB +: 2]);
               n.clk3_rate = tdm_timing_pkg::clock_rate_t'(pwdata[`CTRL_CLK3_RATE_LSB +: 2]);
               n.clk4_sel = pwdata[`CTRL_CLK4_SEL_BIT];
               n.slv_pll = pwdata[`CTRL_SLAVE_PLL_BIT];
            end
            `REF_CHANGE_OFFSET: begin
               n.preferred = pwdata[1:0];
               n.forced = pwdata[`RCC_FORCE_BIT];
            end
            `OFFSET0_OFFSET: n.off0 = pwdata[7:0];
            `OFFSET1_OFFSET: n.off1 = pwdata[7:0];
            `THIRD_OFFSET_OFFSET: begin
               n.off2 = pwdata[7:0];
               n.sonet_sel = pwdata[`SONET_SELECT_BIT];
            end
            default: ;
         endcase
      end

      // strap caught once, on the first edge after reset release
      if (!r.strap_ok) begin
         n.strap_ok = 1'b1;
         n.osc_present = external_oscillator_present;
      end
      n.from_osc = r.osc_present;
      // the DPLL cannot run without the oscillator on the board
      n.config_error = dpll_active & ~r.osc_present;

      // reference choice: preferred, or first healthy one unless forced
      if (!r.forced && fail[r.preferred]) begin
         for (int i = 3; i >= 0; i--) begin
            if (!fail[i]) begin
               pick = 2'(i);
            end
         end
      end
      n.selected = pick;
      n.ref_valid = dpll_active & r.osc_present & ~fail[pick];
      n.ref_out = dpll_active & dpll_reference_inputs[pick];

      // frame timing; slaves and oscillator-less masters follow the input pulse
      n.fp_prev = input_frame_pulse;
      realign = input_frame_pulse & ~r.fp_prev &
                ((r.mode != tdm_timing_pkg::MODE_MASTER) | ~r.osc_present);
      boundary = realign | (r.frame_count == 16'(FRAME_CYCLES - 1));
      n.frame_count = boundary ? 16'h0000 : r.frame_count + 16'h0001;

      // divided slave clamps the first four clocks to the input clock rate
      for (int i = 0; i < 4; i++) begin
         eff_rate[i] = (i == 3) ? {2'b00, r.clk3_rate} : 4'(i);
         if (r.mode == tdm_timing_pkg::MODE_DIVIDED_SLAVE && eff_rate[i] > {2'b00, r.cki_rate}) begin
            eff_rate[i] = {2'b00, r.cki_rate};
         end
      end
      for (int i = 0; i < 6; i++) begin
         if (i < 4) begin
            case (eff_rate[i][1:0])
               2'h0: inc = `INC_4M096;
               2'h1: inc = `INC_8M192;
               2'h2: inc = `INC_16M384;
               default: inc = `INC_32M768;
            endcase
         end else if (i == 4) begin
            inc = r.clk4_sel ? `INC_2M048 : `INC_1M544;
         end else begin
            inc = `INC_19M44;
         end
         if (i >= 4 && !dpll_active) begin
            n.acc[i] = 32'h00000000;
         end else if (boundary && i != 4) begin
            // restart phase of every clock but the fifth so its edge lines up with its pulse
            n.acc[i] = 32'h00000000;
         end else begin
            n.acc[i] = r.acc[i] + inc;
         end
      end

      // one pclk wide pulses, so never wider than the input pulse
      n.fp_aligned = {4{boundary}};
      n.fp_offset[0] = ~boundary & (n.frame_count == 16'(r.off0 * CHAN_CYCLES));
      n.fp_offset[1] = ~boundary & (n.frame_count == 16'(r.off1 * CHAN_CYCLES));
      if (r.sonet_sel) begin
         n.fp_third = boundary & dpll_active;
      end else begin
         n.fp_third = ~boundary & (n.frame_count == 16'(r.off2 * CHAN_CYCLES));
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   ////////////////////////////////////////////////////////////////
   // outputs, all from flops
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign prdata = r.prdata;
   assign master_clock_from_oscillator = r.from_osc;
   assign reference_loss_flags = fail;
   assign selected_reference = r.selected;
   assign reference_valid = r.ref_valid;
   assign dpll_reference_out = r.ref_out;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_clk
         assign generated_clock_outputs[gi] = r.acc[gi][31];
      end
   endgenerate
   assign aligned_frame_pulses = r.fp_aligned;
   assign offset_frame_pulses = r.fp_offset;
   assign third_offset_frame_pulse = r.fp_third;

   ////////////////////////////////////////////////////////////////
   property p_strap_source;
      @(posedge pclk) disable iff (!presetn)
      $rose(r.strap_ok) |=> master_clock_from_oscillator == $past(external_oscillator_present, 2);
   endproperty
   a_strap_source: assert property (p_strap_source) else $error("timing source differs from strap");

   property p_flags_low_slave;
      @(posedge pclk) disable iff (!presetn)
      !dpll_active [*2] |-> reference_loss_flags == 4'h0;
   endproperty
   a_flags_low_slave: assert property (p_flags_low_slave) else $error("loss flag high in slave mode");

   property p_refs_ignored;
      @(posedge pclk) disable iff (!presetn)
      !dpll_active |=> !reference_valid && !dpll_reference_out;
   endproperty
   a_refs_ignored: assert property (p_refs_ignored) else $error("reference used in slave mode");

   property p_pll_clocks_off;
      @(posedge pclk) disable iff (!presetn)
      !dpll_active |=> generated_clock_outputs[5:4] == 2'b00;
   endproperty
   a_pll_clocks_off: assert property (p_pll_clocks_off) else $error("pll clocks run in slave mode");

   property p_sonet_gated;
      @(posedge pclk) disable iff (!presetn)
      (!dpll_active && r.sonet_sel) |=> !third_offset_frame_pulse;
   endproperty
   a_sonet_gated: assert property (p_sonet_gated) else $error("sonet pulse in slave mode");

   property p_sonet_aligned;
      @(posedge pclk) disable iff (!presetn)
      (dpll_active && r.sonet_sel) |=> third_offset_frame_pulse == aligned_frame_pulses[0];
   endproperty
   a_sonet_aligned: assert property (p_sonet_aligned) else $error("sonet pulse not aligned");

   property p_offset_place;
      @(posedge pclk) disable iff (!presetn)
      offset_frame_pulses[0] |-> r.frame_count == 16'($past(r.off0) * CHAN_CYCLES) && !aligned_frame_pulses[0];
   endproperty
   a_offset_place: assert property (p_offset_place) else $error("offset pulse misplaced");

   property p_pulse_spacing;
      @(posedge pclk) disable iff (!presetn)
      (aligned_frame_pulses[0] && FRAME_CYCLES > 9) |=> !aligned_frame_pulses[0] [*8];
   endproperty
   a_pulse_spacing: assert property (p_pulse_spacing) else $error("frame pulses too close");

   property p_divided_clamp;
      @(posedge pclk) disable iff (!presetn)
      r.mode == tdm_timing_pkg::MODE_DIVIDED_SLAVE |-> eff_rate[3] <= {2'b00, r.cki_rate};
   endproperty
   a_divided_clamp: assert property (p_divided_clamp) else $error("clock above input rate");

   property p_forced_ref;
      @(posedge pclk) disable iff (!presetn)
      r.forced |=> selected_reference == $past(r.preferred);
   endproperty
   a_forced_ref: assert property (p_forced_ref) else $error("forced reference not used");

   c_fail_over: cover property (@(posedge pclk) disable iff (!presetn) !r.forced && fail[r.preferred] && !fail[0]);
   c_sonet: cover property (@(posedge pclk) disable iff (!presetn) third_offset_frame_pulse && r.sonet_sel);
   c_offset: cover property (@(posedge pclk) disable iff (!presetn) offset_frame_pulses[1]);
   c_slave_pll: cover property (@(posedge pclk) disable iff (!presetn) r.slv_pll && r.mode != 2'h0);

endmodule : tdm_timing_core

// ### tdm_timing_pkg.sv
// types for the timing output and reference status block
// assumes tdm_timing_regs.svh for all numbers
package tdm_timing_pkg;

   typedef enum logic [1:0] {
      MODE_MASTER,
      MODE_DIVIDED_SLAVE,
      MODE_MULTIPLIED_SLAVE,
      MODE_SPARE
   } timing_mode_t;

   typedef enum logic [1:0] {
      RATE_4M096,
      RATE_8M192,
      RATE_16M384,
      RATE_32M768
   } clock_rate_t;

   typedef struct packed {
      logic prev;
      logic [15:0] count;
      logic fail;
   } monitor_state_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      timing_mode_t mode;
      clock_rate_t cki_rate;
      clock_rate_t clk3_rate;
      logic clk4_sel;
      logic slv_pll;
      logic [1:0] preferred;
      logic forced;
      logic [7:0] off0;
      logic [7:0] off1;
      logic [7:0] off2;
      logic sonet_sel;
      logic strap_ok;
      logic osc_present;
      logic from_osc;
      logic fp_prev;
      logic [15:0] frame_count;
      logic [5:0][31:0] acc;
      logic [3:0] fp_aligned;
      logic [1:0] fp_offset;
      logic fp_third;
      logic [1:0] selected;
      logic ref_valid;
      logic ref_out;
      logic config_error;
   } timing_state_t;

endpackage : tdm_timing_pkg

// ### tdm_timing_regs.svh
// constants for the timing output and reference status block
// assumes a 40 MHz pclk and an APB register port
//
// How it works
// - strap high: master timing comes from the external 20 MHz oscillator.
// - strap low: master timing follows the input frame pulse instead.
// - master mode: each reference accepts 8 kHz up to 19.44 MHz independently.
// - one reference is preferred or forced, chosen by reference change control.
// - slave mode ignores all references unless slave PLL enable bit 13 is set.
// - master mode: reference 0 failure drives its loss flag high.
// - slave mode drives all loss flags low unless slave PLL enable is set.
// - three fixed 8 kHz frame pulses aligned to the 4, 8 and 16 MHz clocks.
// - fourth frame pulse follows the programmable fourth clock rate.
// - divided slave frame pulses may be narrower than the input frame pulse.
// - two offset pulses, each displaced by its own programmable channel count.
// - third offset pulse becomes a 19.44 MHz aligned pulse when bit 10 set.
// - the 19.44 MHz aligned pulse exists only in master or slave-with-PLL mode.
// - fourth clock selects 4/8/16/32 MHz; first three are fixed 4, 8, 16 MHz.
// - divided slave: first four clocks never exceed the input bit clock rate.
// - fifth and sixth clocks run only in master or slave-with-PLL mode.
`ifndef TDM_TIMING_REGS_SVH
`define TDM_TIMING_REGS_SVH

`define MAIN_CONTROL_OFFSET 8'h00
`define REF_CHANGE_OFFSET 8'h04
`define OFFSET0_OFFSET 8'h08
`define OFFSET1_OFFSET 8'h0c
`define THIRD_OFFSET_OFFSET 8'h10
`define STATUS_OFFSET 8'h14

`define MAIN_CONTROL_RESET 32'h00000000
`define CTRL_MODE_LSB 0
`define CTRL_CKI_RATE_LSB 2
`define CTRL_CLK3_RATE_LSB 4
`define CTRL_CLK4_SEL_BIT 6
`define CTRL_SLAVE_PLL_BIT 13
`define RCC_FORCE_BIT 2
`define SONET_SELECT_BIT 10

`define PCLK_PERIOD_NS 25
`define FRAME_PERIOD_NS 125000
`define FRAME_CYCLES (`FRAME_PERIOD_NS / `PCLK_PERIOD_NS)
`define REF_TIMEOUT_NS 250000
`define REF_TIMEOUT_CYCLES (`REF_TIMEOUT_NS / `PCLK_PERIOD_NS)
`define CHANNELS_PER_FRAME 256

// phase increments, rate / 40 MHz * 2^32
`define INC_4M096 32'h1a36e2eb
`define INC_8M192 32'h346dc5d6
`define INC_16M384 32'h68db8bac
`define INC_32M768 32'hd1b71758
`define INC_1M544 32'h09e1b85a
`define INC_2M048 32'h0d1b7175
`define INC_19M44 32'h7c6a7ef9

`endif

// ### timing_output_and_reference_status_bench.sv
// self-checking bench for the timing core
// assumes tdm_timing_core and frame_sink_model are compiled first
`timescale 1ns/1ps

module timing_output_and_reference_status_bench;
   localparam int FC = 400;
   localparam int TO = 50;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic strap = 1'b1;
   logic bitclk = 1'b0;
   logic fpin = 1'b0;
   logic [3:0] refs = 4'h0;
   logic [3:0] ref_run = 4'h0;
   logic pready, pslverr, mclk, rvalid, rout, fp3, apart, rerr;
   logic [31:0] prdata, rdata;
   logic [3:0] flags, fpa;
   logic [1:0] sel, fpo;
   logic [5:0] ck;
   logic [15:0] period;
   logic [2:0][15:0] pos;
   logic [2:0] hit;
   logic [5:0][15:0] edges;
   int mismatches = 0;
   int total_checks = 0;
   int cycles = 0;
   int ph = 0;
   int al = 0;

   tdm_timing_core #(.FRAME_CYCLES(FC), .REF_TIMEOUT_CYCLES(TO)) i_tdm_timing_core (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .external_oscillator_present(strap), .input_bit_clock(bitclk), .input_frame_pulse(fpin),
      .master_clock_from_oscillator(mclk), .dpll_reference_inputs(refs),
      .reference_loss_flags(flags), .selected_reference(sel), .reference_valid(rvalid),
      .dpll_reference_out(rout), .generated_clock_outputs(ck), .aligned_frame_pulses(fpa),
      .offset_frame_pulses(fpo), .third_offset_frame_pulse(fp3));
   frame_sink_model i_frame_sink_model (.pclk(pclk), .presetn(presetn), .clocks(ck),
      .frames(fpa), .offsets({fp3, fpo}), .period(period), .pos(pos), .hit(hit),
      .edges(edges), .apart(apart));

   ////////////////////////////////////////////////////////////////////////////
   always #12.5 pclk = ~pclk;

   always @(posedge pclk) begin
      cycles <= cycles + 1;
      bitclk <= ~bitclk;
      fpin <= ((cycles + ph) % FC) == 0;
      if (cycles % 8 == 0)
         refs <= refs ^ ref_run;
      if (fpa[0] === 1'b1)
         al <= (cycles + ph) % FC;
      if (cycles == 20000) begin
         mismatches++;
         conclude();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      if (mismatches == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_in(input logic [15:0] got, input int lo, input int hi);
      total_checks++;
      if ($isunknown(got) || got < lo || got > hi) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h to %h", $time, got, lo, hi);
      end
   endtask : chk_in

   // edges of a clock of r kHz seen in one frame of FC cycles at 40 MHz
   task automatic rate(input logic [15:0] got, input int r);
      chk_in(got, r * FC / 40000 - 1, r * FC / 40000 + 1);
   endtask : rate

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // read before the edge's updates land, i.e. what the core sampled here
      while (pready !== 1'b1)
         @(posedge pclk);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask : idle

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk({flags, fpa, ck, fpo, fp3, pready}, 32'h00000000);
      presetn <= 1'b1;
      idle(4);
      chk(mclk, 1'b1);
      apb(1'b0, 8'h00, 32'h00000000);
      chk(rdata, 32'h00000000);
      apb(1'b0, 8'h14, 32'h00000000);
      chk(rdata[7], 1'b1);
      apb(1'b0, 8'h18, 32'h00000000);
      chk(rerr, 1'b1);
      chk(rdata, 32'h00000000);
      apb(1'b1, 8'h08, 32'h0000000a);
      apb(1'b0, 8'h08, 32'h00000000);
      chk(rdata, 32'h0000000a);
   endtask : t_reset

   task automatic t_frames();
      apb(1'b1, 8'h0c, 32'h00000028);
      apb(1'b1, 8'h10, 32'h00000019);
      idle(2 * FC + 8);
      chk(period, FC);
      chk(apart, 1'b0);
      chk(pos[1] - pos[0], 30);
      chk(pos[2] - pos[0], 15);
      apb(1'b1, 8'h08, 32'h00000000);
      apb(1'b1, 8'h10, 32'h00000419);
      idle(2 * FC + 8);
      chk(hit, 3'b110);
      chk_in(pos[2], 0, 1);
   endtask : t_frames

   task automatic t_clocks();
      int rk [3] = '{4096, 8192, 16384};
      for (int c = 0; c < 3; c++) begin
         apb(1'b1, 8'h00, (c << 4) | (c[0] << 6));
         idle(2 * FC + 8);
         for (int i = 0; i < 3; i++) begin
            rate(edges[i], rk[i]);
         end
         rate(edges[3], rk[c]);
         rate(edges[4], c[0] ? 2048 : 1544);
         rate(edges[5], 19440);
      end
   endtask : t_clocks

   task automatic t_refs();
      apb(1'b1, 8'h00, 32'h00000000);
      ref_run <= 4'b0110;
      idle(4 * TO);
      chk(flags, 4'h9);
      apb(1'b1, 8'h04, 32'h00000000);
      idle(2);
      chk(sel, 2'h1);
      apb(1'b1, 8'h04, 32'h00000004);
      idle(2);
      chk(sel, 2'h0);
      chk(rvalid, 1'b0);
      apb(1'b1, 8'h04, 32'h00000002);
      idle(2);
      chk(sel, 2'h2);
      chk(rvalid, 1'b1);
      ref_run <= 4'b1111;
      idle(40);
      chk(flags, 4'h0);
   endtask : t_refs

   task automatic t_slave();
      ref_run <= 4'b0111;
      apb(1'b1, 8'h00, 32'h00000031);
      idle(2 * FC + 8);
      chk(flags, 4'h0);
      chk({rvalid, rout}, 32'h00000000);
      chk(hit[2], 1'b0);
      chk({edges[5], edges[4]}, 32'h00000000);
      for (int i = 0; i < 4; i++) begin
         chk_in(edges[i], 0, 4096 * FC / 40000 + 1);
      end
      apb(1'b1, 8'h00, 32'h00002032);
      idle(2 * FC + 8);
      chk(flags, 4'h8);
      chk(hit[2], 1'b1);
      rate(edges[5], 19440);
   endtask : t_slave

   task automatic t_strap();
      @(posedge pclk);
      presetn <= 1'b0;
      strap <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      idle(4);
      chk(mclk, 1'b0);
      apb(1'b0, 8'h14, 32'h00000000);
      chk(rdata[8:7], 32'h00000002);
      ph = 123;
      idle(2 * FC + 8);
      chk(period, FC);
      chk_in(16'(al), 0, 6);
   endtask : t_strap

   initial begin
      repeat (3) @(posedge pclk);
      t_reset();
      t_frames();
      t_clocks();
      t_refs();
      t_slave();
      t_strap();
      conclude();
   end
endmodule : timing_output_and_reference_status_bench
